// File: rtl/sarc_control.sv
// Control of a 10-bit successive approximation converter: start, timing, result lock
// ----------------------------------------------------------------
// Summary of operation
// - Ten-bit result, right or left justified
// - Low byte read locks both result bytes
// - High byte read unlocks result bytes
// - Done flag set even when result discarded
// - Start bit launches, reads high, self-clears
// - Channel change waits for current conversion
// - Trigger edge restarts prescaler and converts
// - Trigger edges during conversion are ignored
// - Trigger flag must be cleared by software
// - Own done flag as trigger free-runs
// - Start bit works and reads busy anyway
// - Prescaler runs only while enable set
// - Software start waits for converter clock edge
// - Thirteen cycles normal, twenty-five first
// - Sample at 1.5, first at 13.5
// - Completion writes result, sets flag, clears start
// - Auto sample at two cycles, 13.5 long
// - Free-running restarts at once, start stays high
// - Selections apply only while enable set
// - Differential codes use 8x/20x gain, else bypass
// - Five-bit channel field selects all inputs
// - Reference from select field and enable bits
// - Selection buffer frozen until last cycle
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "sarc_regs.svh"

module sarc_control (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // Software control bits
  input  wire logic                  converter_enable,
  input  wire logic                  start_conversion_write,
  input  wire logic                  auto_trigger_enable,
  input  wire logic [2:0]            trigger_select,
  input  wire logic [2:0]            prescaler_select,
  input  wire logic                  result_left_justify,
  input  wire logic [4:0]            channel_select,
  input  wire logic [1:0]            reference_select,
  input  wire logic                  reference_output_enable,
  input  wire logic                  external_reference_enable,
  input  wire logic                  conversion_done_clear,
  // Result byte read strobes
  input  wire logic                  result_low_read,
  input  wire logic                  result_high_read,
  // Trigger sources, bit n picked by trigger_select n
  input  wire logic [7:0]            trigger_sources,
  // Analog core
  input  wire logic [`SARC_RES_W-1:0] sar_result,
  output logic                       analog_enable,
  output logic                       sample_hold,
  output logic [4:0]                 channel_applied,
  output sarc_pkg::sarc_gain_e       gain_applied,
  output sarc_pkg::sarc_ref_e        reference_applied,
  output logic                       reference_drive_out,
  // Status to software
  output logic                       start_conversion,
  output logic                       conversion_done_flag,
  output logic                       conversion_done_pulse,
  output logic [7:0]                 result_high_byte,
  output logic [7:0]                 result_low_byte
);
  import sarc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sarc_state_e              state;
  sarc_state_e              next_state;
  logic [`SARC_HCNT_W-1:0]  hcnt;
  logic [`SARC_HCNT_W-1:0]  next_hcnt;
  logic [`SARC_HCNT_W-1:0]  cur_end;
  logic [`SARC_HCNT_W-1:0]  cur_samp;
  logic [`SARC_HCNT_W-1:0]  next_end;
  logic [`SARC_HCNT_W-1:0]  next_samp;
  logic                     first_conv;
  logic                     result_locked;
  logic                     tick_rise;
  logic                     tick_fall;
  logic                     tick_any;
  logic                     done_evt;
  logic                     enter_conv;
  logic                     trig_start;
  logic                     free_run;
  logic                     near_end;
  logic                     trig_q1;
  logic                     trig_q2;
  logic                     trig_q3;
  logic                     trig_level;
  logic                     trig_level_d;
  logic                     trig_edge;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  sarc_prescaler i_sarc_prescaler (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .run              (converter_enable),
    .restart          (trig_start),
    .prescaler_select (prescaler_select),
    .tick_rise        (tick_rise),
    .tick_fall        (tick_fall)
  );

  assign tick_any = tick_rise || tick_fall;

  // ----------------------------------------------------------------
  // Trigger synchroniser and edge detect
  // ----------------------------------------------------------------
  // Three stages; the level moves only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trig_q1      <= 1'b0;
      trig_q2      <= 1'b0;
      trig_q3      <= 1'b0;
      trig_level   <= 1'b0;
      trig_level_d <= 1'b0;
    end else begin
      trig_q1      <= trigger_sources[trigger_select];
      trig_q2      <= trig_q1;
      trig_q3      <= trig_q2;
      if (trig_q2 == trig_q3) begin
        trig_level <= trig_q3;
      end
      trig_level_d <= trig_level;
    end
  end

  // A level still high at completion gives no edge, so no restart
  assign trig_edge = trig_level && !trig_level_d;
  assign free_run  = auto_trigger_enable && (trigger_select == `SARC_TS_FREE_RUN);
  assign trig_start = (state == SARC_IDLE) && converter_enable && auto_trigger_enable
                      && !free_run && trig_edge && !start_conversion_write;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  assign done_evt = (state == SARC_CONVERT) && tick_any && (hcnt + 6'd1 == cur_end);
  assign near_end = (hcnt >= cur_end - `SARC_LAST_CYCLE);

  // Next state, half-cycle count and timing of the conversion being entered
  always_comb begin
    next_state = state;
    next_hcnt  = hcnt;
    enter_conv = 1'b0;
    next_end   = cur_end;
    next_samp  = cur_samp;
    case (state)
      SARC_IDLE: begin
        if (start_conversion_write) begin
          next_state = SARC_WAIT_EDGE;
        end else if (trig_start) begin
          next_state = SARC_CONVERT;
          next_hcnt  = 6'd0;
          enter_conv = 1'b1;
        end
      end
      SARC_WAIT_EDGE: begin
        if (tick_rise) begin
          next_state = SARC_CONVERT;
          next_hcnt  = 6'd0;
          enter_conv = 1'b1;
        end
      end
      SARC_CONVERT: begin
        if (done_evt) begin
          next_hcnt = 6'd0;
          if (free_run) begin
            enter_conv = 1'b1;
          end else begin
            next_state = SARC_IDLE;
          end
        end else if (tick_any) begin
          next_hcnt = hcnt + 6'd1;
        end
      end
      default: begin
        next_state = SARC_IDLE;
      end
    endcase
    if (enter_conv) begin
      if (first_conv) begin
        next_end  = `SARC_FIRST_END;
        next_samp = `SARC_FIRST_SAMP;
      end else if (trig_start) begin
        next_end  = `SARC_AUTO_END;
        next_samp = `SARC_AUTO_SAMP;
      end else begin
        next_end  = `SARC_NORM_END;
        next_samp = `SARC_NORM_SAMP;
      end
    end
  end

  // Sequencer state; dropping enable abandons any conversion
  always_ff @(posedge mclk) begin
    if (sys_rst || !converter_enable) begin
      state    <= SARC_IDLE;
      hcnt     <= 6'd0;
      cur_end  <= `SARC_NORM_END;
      cur_samp <= `SARC_NORM_SAMP;
    end else begin
      state    <= next_state;
      hcnt     <= next_hcnt;
      cur_end  <= next_end;
      cur_samp <= next_samp;
    end
  end

  // First conversion after enable gets the long initialisation timing
  always_ff @(posedge mclk) begin
    if (sys_rst || !converter_enable) begin
      first_conv <= 1'b1;
    end else if (enter_conv) begin
      first_conv <= 1'b0;
    end
  end

  // Start bit reads one while waiting or converting, by any cause
  always_ff @(posedge mclk) begin
    if (sys_rst || !converter_enable) begin
      start_conversion <= 1'b0;
    end else begin
      start_conversion <= (next_state != SARC_IDLE);
    end
  end

  // Sample strobe when the half-cycle count reaches the sample point
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= (state == SARC_CONVERT) && tick_any && !done_evt
                     && (hcnt + 6'd1 == cur_samp);
    end
  end

  // ----------------------------------------------------------------
  // Result bytes, lock and completion flag
  // ----------------------------------------------------------------
  // High read wins over a low read in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result_locked <= 1'b0;
    end else if (result_high_read) begin
      result_locked <= 1'b0;
    end else if (result_low_read) begin
      result_locked <= 1'b1;
    end
  end

  // A locked pair keeps the older result; the new one is lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result_high_byte <= `SARC_BYTE_RST;
      result_low_byte  <= `SARC_BYTE_RST;
    end else if (done_evt && !result_locked) begin
      if (result_left_justify) begin
        result_high_byte <= sar_result[9:2];
        result_low_byte  <= {sar_result[1:0], 6'h00};
      end else begin
        result_high_byte <= {6'h00, sar_result[9:8]};
        result_low_byte  <= sar_result[7:0];
      end
    end
  end

  // Completion sets the flag even when the result was dropped; set beats clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conversion_done_flag  <= 1'b0;
      conversion_done_pulse <= 1'b0;
    end else begin
      conversion_done_pulse <= done_evt;
      if (done_evt) begin
        conversion_done_flag <= 1'b1;
      end else if (conversion_done_clear) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel and reference buffer
  // ----------------------------------------------------------------
  // Frozen during a conversion until its last converter cycle so sampling sees a settled input
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      channel_applied     <= `SARC_CHAN_RST;
      gain_applied        <= SARC_GAIN_BYPASS;
      reference_applied   <= SARC_SRC_AVCC;
      reference_drive_out <= 1'b0;
    end else if (converter_enable && (state != SARC_CONVERT || near_end)) begin
      channel_applied <= channel_select;
      if (channel_select >= `SARC_DIFF_BASE) begin
        gain_applied <= channel_select[0] ? SARC_GAIN_20X : SARC_GAIN_8X;
      end else begin
        gain_applied <= SARC_GAIN_BYPASS;
      end
      if (external_reference_enable) begin
        reference_applied <= SARC_SRC_PIN;
      end else if (reference_select == `SARC_REF_PIN) begin
        reference_applied <= SARC_SRC_PIN;
      end else if (reference_select == `SARC_REF_1V1) begin
        reference_applied <= SARC_SRC_1V1;
      end else if (reference_select == `SARC_REF_2V56) begin
        reference_applied <= SARC_SRC_2V56;
      end else begin
        reference_applied <= SARC_SRC_AVCC;
      end
      reference_drive_out <= reference_output_enable && !external_reference_enable
                             && reference_select[1];
    end
  end

  // Analog core powered only while enabled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      analog_enable <= 1'b0;
    end else begin
      analog_enable <= converter_enable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_lock_holds;
    @(posedge mclk) disable iff (sys_rst)
    (done_evt && result_locked) |=> ($stable(result_high_byte) && $stable(result_low_byte));
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked result bytes changed");

  property p_high_unlocks;
    @(posedge mclk) disable iff (sys_rst)
    result_high_read |=> !result_locked;
  endproperty
  a_high_unlocks: assert property (p_high_unlocks) else $error("high read left lock set");

  property p_flag_on_done;
    @(posedge mclk) disable iff (sys_rst)
    done_evt |=> (conversion_done_flag && conversion_done_pulse);
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("done flag not raised");

  property p_busy_reads_one;
    @(posedge mclk) disable iff (sys_rst)
    (state == SARC_CONVERT && !done_evt && converter_enable) |=> start_conversion;
  endproperty
  a_busy_reads_one: assert property (p_busy_reads_one) else $error("start bit low while busy");

  property p_prescaler_held;
    @(posedge mclk) disable iff (sys_rst)
    !converter_enable |-> (!tick_rise && !tick_fall);
  endproperty
  a_prescaler_held: assert property (p_prescaler_held) else $error("prescaler ran while disabled");

  property p_edge_ignored;
    @(posedge mclk) disable iff (sys_rst)
    (state == SARC_CONVERT && trig_edge && !done_evt && converter_enable)
      |=> (state == SARC_CONVERT && hcnt >= $past(hcnt));
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("trigger accepted while busy");

  property p_buffer_frozen;
    @(posedge mclk) disable iff (sys_rst)
    (state == SARC_CONVERT && !near_end) |=> $stable(channel_applied);
  endproperty
  a_buffer_frozen: assert property (p_buffer_frozen) else $error("channel changed mid conversion");

  property p_disabled_no_apply;
    @(posedge mclk) disable iff (sys_rst)
    !converter_enable |=> $stable(reference_applied);
  endproperty
  a_disabled_no_apply: assert property (p_disabled_no_apply) else $error("reference applied while disabled");

  property p_free_run_restart;
    @(posedge mclk) disable iff (sys_rst)
    (done_evt && free_run && converter_enable) |=> (state == SARC_CONVERT && start_conversion && hcnt == 6'd0);
  endproperty
  a_free_run_restart: assert property (p_free_run_restart) else $error("free run did not restart");

  property p_start_waits_edge;
    @(posedge mclk) disable iff (sys_rst)
    (state == SARC_WAIT_EDGE && !tick_rise && converter_enable) |=> (state == SARC_WAIT_EDGE);
  endproperty
  a_start_waits_edge: assert property (p_start_waits_edge) else $error("start left wait before edge");

  property p_norm_length;
    @(posedge mclk) disable iff (sys_rst)
    (enter_conv && !first_conv && !trig_start) |=> (cur_end == 6'd26 && cur_samp == 6'd3);
  endproperty
  a_norm_length: assert property (p_norm_length) else $error("normal length not 13 cycles");
endmodule // sarc_control

`default_nettype wire

// File: rtl/sarc_pkg.sv
// Types shared by the converter control modules
package sarc_pkg;
  typedef enum logic [1:0] {
    SARC_IDLE,
    SARC_WAIT_EDGE,
    SARC_CONVERT
  } sarc_state_e;

  typedef enum logic [1:0] {
    SARC_GAIN_BYPASS,
    SARC_GAIN_8X,
    SARC_GAIN_20X
  } sarc_gain_e;

  typedef enum logic [1:0] {
    SARC_SRC_AVCC,
    SARC_SRC_PIN,
    SARC_SRC_1V1,
    SARC_SRC_2V56
  } sarc_ref_e;
endpackage

// File: rtl/sarc_prescaler.sv
// Converter clock prescaler giving rise and fall ticks of the divided clock
`timescale 1ns/1ps
`default_nettype none
`include "sarc_regs.svh"

module sarc_prescaler (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] prescaler_select,
  // Ticks of the divided clock
  output logic            tick_rise,
  output logic            tick_fall
);
  import sarc_pkg::*;

  logic [`SARC_PSC_W-1:0] count;
  logic [`SARC_PSC_W-1:0] wrap_at;
  logic [`SARC_PSC_W-1:0] half_at;

  // Ratios 2,2,4,8..128; kept one below the ratio so divide by 128 still fits seven bits
  always_comb begin
    wrap_at = (prescaler_select == 3'h0) ? 7'h01 : 7'((8'h01 << prescaler_select) - 8'h01);
    half_at = wrap_at >> 1;
  end

  // Held at zero while disabled so the first rising edge is a full period away
  always_ff @(posedge mclk) begin
    if (sys_rst || !run || restart) begin
      count <= 7'h00;
    end else if (count == wrap_at) begin
      count <= 7'h00;
    end else begin
      count <= count + 7'h01;
    end
  end

  // Ticks are qualified with run so a held prescaler gives none
  always_comb begin
    tick_rise = run && !restart && (count == wrap_at);
    tick_fall = run && !restart && (count == half_at);
  end
endmodule // sarc_prescaler

`default_nettype wire

// File: rtl/sarc_regs.svh
// Timing counts, field codes and reset values of the converter control block
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SARC_RES_W        10
`define SARC_HCNT_W       6
`define SARC_PSC_W        7

// ----------------------------------------------------------------
// Conversion timing, in converter clock half cycles
// ----------------------------------------------------------------
`define SARC_NORM_END     6'd26
`define SARC_NORM_SAMP    6'd3
`define SARC_FIRST_END    6'd50
`define SARC_FIRST_SAMP   6'd27
`define SARC_AUTO_END     6'd27
`define SARC_AUTO_SAMP    6'd4
`define SARC_LAST_CYCLE   6'd2

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define SARC_TS_FREE_RUN  3'h0
`define SARC_DIFF_BASE    5'h10
`define SARC_REF_AVCC     2'h0
`define SARC_REF_PIN      2'h1
`define SARC_REF_1V1      2'h2
`define SARC_REF_2V56     2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SARC_CHAN_RST     5'h00
`define SARC_REF_RST      2'h0
`define SARC_BYTE_RST     8'h00

`endif

// File: tb/sarc_control_tb_top.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module sarc_control_tb_top;
  import sarc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        en = 1'b0, sw = 1'b0, ate = 1'b0, lj = 1'b0;
  logic        roe = 1'b0, xre = 1'b0, dclr = 1'b0, rdl = 1'b0, rdh = 1'b0;
  logic [2:0]  tsel = 3'h1, psel = 3'h0;
  logic [4:0]  csel = 5'h00;
  logic [1:0]  rsel = 2'h0;
  logic [7:0]  trig = 8'h00;
  logic [9:0]  sar = 10'h2a5;
  logic        ana_en, smp, rdrv, busy, flag, dpulse;
  logic [4:0]  chan;
  sarc_gain_e  gain;
  sarc_ref_e   refa;
  logic [7:0]  hi, lo;
  int          failures = 0, n_checks = 0, cyc = 0;

  sarc_control i_sarc_control (
    .mclk(mclk), .sys_rst(sys_rst), .converter_enable(en), .start_conversion_write(sw),
    .auto_trigger_enable(ate), .trigger_select(tsel), .prescaler_select(psel),
    .result_left_justify(lj), .channel_select(csel), .reference_select(rsel),
    .reference_output_enable(roe), .external_reference_enable(xre), .conversion_done_clear(dclr),
    .result_low_read(rdl), .result_high_read(rdh), .trigger_sources(trig), .sar_result(sar),
    .analog_enable(ana_en), .sample_hold(smp), .channel_applied(chan), .gain_applied(gain),
    .reference_applied(refa), .reference_drive_out(rdrv), .start_conversion(busy),
    .conversion_done_flag(flag), .conversion_done_pulse(dpulse), .result_high_byte(hi),
    .result_low_byte(lo)
  );

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  // Cycle count doubles as timestamp and hang guard; whole run is under 2000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc >= 5000) begin
      failures++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Settle past the edge so registered outputs are stable when sampled
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic start_it();
    @(posedge mclk);
    sw <= 1'b1;
    @(posedge mclk);
    sw <= 1'b0;
    #1;
    chk(busy === 1'b1, "start bit not high after start");
  endtask

  task automatic rd(input logic l, input logic h);
    @(posedge mclk);
    rdl <= l;
    rdh <= h;
    @(posedge mclk);
    rdl <= 1'b0;
    rdh <= 1'b0;
  endtask

  // Counts completions over n cycles; times are absolute cycle numbers
  task automatic watch(input int n, output int p, output int f, output int s, output logic held);
    p = 0;
    f = 0;
    s = 0;
    held = 1'b1;
    repeat (n) begin
      step(1);
      if (smp === 1'b1) s = cyc;
      if (dpulse === 1'b1) begin
        p++;
        if (f == 0) f = cyc;
        chk(flag === 1'b1, "flag not set at completion");
      end else if (busy !== 1'b1) held = 1'b0;
    end
  endtask

  // Single conversion with its length bounds in cycles, sample-to-end fixed at 23 half-clocks of t cycles
  task automatic conv(input int lo_n, input int hi_n, input int t = 1);
    int p, f, s, c0;
    logic h;
    start_it();
    c0 = cyc;
    watch(hi_n + 4, p, f, s, h);
    chk(p == 1 && f - c0 >= lo_n && f - c0 <= hi_n, "conversion length");
    chk(f - s == 23 * t, "sample point");
    chk(busy === 1'b0, "start bit not cleared");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int p, f, s;
    logic h;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    step(1);
    chk(busy === 1'b0 && flag === 1'b0 && hi === 8'h00 && lo === 8'h00, "reset outputs");
    chk(chan === 5'h00 && gain === SARC_GAIN_BYPASS && refa === SARC_SRC_AVCC, "reset selection");
    // Selections must wait for enable
    csel <= 5'h12;
    rsel <= 2'h3;
    roe <= 1'b1;
    step(4);
    chk(chan === 5'h00 && refa === SARC_SRC_AVCC, "selection taken while disabled");
    en <= 1'b1;
    step(4);
    chk(chan === 5'h12 && gain === SARC_GAIN_8X && ana_en === 1'b1, "differential 8x");
    chk(refa === SARC_SRC_2V56 && rdrv === 1'b1, "internal reference");
    conv(50, 55);
    chk(hi === 8'h02 && lo === 8'ha5, "right justified bytes");
    dclr <= 1'b1;
    step(1);
    dclr <= 1'b0;
    step(1);
    chk(flag === 1'b0, "flag not cleared");
    // Left justify, then lock by low read
    lj <= 1'b1;
    conv(26, 31);
    chk(hi === 8'ha9 && lo === 8'h40, "left justified bytes");
    rd(1'b1, 1'b0);
    dclr <= 1'b1;
    step(1);
    dclr <= 1'b0;
    chk(flag === 1'b0, "flag not cleared before locked run");
    sar <= 10'h155;
    conv(26, 31);
    chk(hi === 8'ha9 && lo === 8'h40, "locked bytes updated");
    rd(1'b0, 1'b1);
    conv(26, 31);
    chk(hi === 8'h55 && lo === 8'h40, "bytes not unlocked by high read");
    // Channel change in mid conversion stays frozen until the last converter cycle
    start_it();
    step(5);
    csel <= 5'h13;
    step(5);
    chk(chan === 5'h12, "channel changed in mid conversion");
    watch(40, p, f, s, h);
    chk(p == 1 && chan === 5'h13 && gain === SARC_GAIN_20X, "channel after completion");
    xre <= 1'b1;
    csel <= 5'h03;
    step(4);
    chk(refa === SARC_SRC_PIN && rdrv === 1'b0, "external reference");
    chk(gain === SARC_GAIN_BYPASS && chan === 5'h03, "single ended bypass");
    // Triggered conversion, a second edge inside it and a held level
    ate <= 1'b1;
    trig <= 8'h02;
    watch(14, p, f, s, h);
    chk(s != 0 && busy === 1'b1, "trigger edge did not start");
    trig <= 8'h00;
    step(3);
    trig <= 8'h02;
    watch(40, p, f, s, h);
    chk(p == 1, "edge during conversion not ignored");
    watch(60, p, f, s, h);
    chk(p == 0, "held trigger restarted");
    trig <= 8'h00;
    step(2);
    trig <= 8'h02;
    watch(45, p, f, s, h);
    chk(p == 1 && f - s == 23, "fresh edge conversion");
    trig <= 8'h00;
    conv(26, 31);
    // Free running on own completion
    tsel <= 3'h0;
    start_it();
    watch(90, p, f, s, h);
    chk(p >= 3 && h === 1'b1, "free run stopped");
    en <= 1'b0;
    ate <= 1'b0;
    step(4);
    chk(busy === 1'b0 && ana_en === 1'b0, "disable did not abort");
    en <= 1'b1;
    step(2);
    conv(50, 55);
    // Divide by four: every half-clock now spans two cycles
    en <= 1'b0;
    psel <= 3'h2;
    step(2);
    en <= 1'b1;
    step(2);
    conv(100, 108, 2);
    end_sim();
  end
endmodule // sarc_control_tb_top

`default_nettype wire
